// ==== sfri_consts.svh ====
// Register map, field positions and reset values of the serial port pair
//
// Behaviour
// [RULE1] Order bit: clear MSB first, set LSB first
// [RULE2] Width bit: clear 8-bit, set 16-bit frames
// [RULE3] Role bit: clear slave, set master drives clock
// [RULE4] Divider code 0..10 gives 2^code, above 1024; here code 0 gives 2, like code 1
// [RULE5] Port runs only while enable bit set
// [RULE6] Polarity bit sets serial clock idle level
// [RULE7] Phase bit: capture on first or second edge
// [RULE8] Collision flag sticky until software writes one
// [RULE9] Live flag: transmit FIFO below half full
// [RULE10] Live flag: receive FIFO above half full
// [RULE11] Live flag: receive FIFO full
// [RULE12] Transmit empty sticky, cleared by W1C or DMA
// [RULE13] Receive not empty set while data, W1C
// [RULE14] Done flag set at end, zero while busy
// [RULE15] Data read pops receive, write pushes transmit
// [RULE16] Software uses whole-word data register accesses only
// [RULE17] Transmit DMA request from empty flag when enabled
// [RULE18] FIFO port receive DMA request from not-empty
// [RULE19] Each FIFO flag interrupts only with its enable
// [RULE20] Master gate blocks every interrupt request
// [RULE21] Buffer port offers collision, empty, done flags only
// [RULE22] Pin group field: three groups or two groups
// [RULE23] Buffer port receive DMA request from done flag
// [RULE24] Data write during transfer sets collision flag only; here the word is also pushed if the FIFO has room
// [RULE25] FIFO depth parameter, reserved bits ignore writes
`ifndef SFRI_CONSTS_SVH
`define SFRI_CONSTS_SVH

// ==========================================================
// Offsets inside one port, port select bit of the bus address
`define SFRI_OFS_CTRL     5'h00
`define SFRI_OFS_FLAGS    5'h04
`define SFRI_OFS_DATA     5'h0c
`define SFRI_OFS_IDE      5'h10
`define SFRI_PORT_SEL_BIT 5

// ==========================================================
// Control fields
`define SFRI_C_ROLE  0
`define SFRI_C_WIDTH 1
`define SFRI_C_ORDER 2
`define SFRI_C_CAPT  3
`define SFRI_C_IDLE  4
`define SFRI_C_EN    7
`define SFRI_C_DIV   11:8
`define SFRI_C_GRP   15:14
`define SFRI_CTRL_WMASK 16'hcf9f

// ==========================================================
// Flag and enable fields
`define SFRI_F_DONE   0
`define SFRI_F_RXNE   1
`define SFRI_F_TXE    2
`define SFRI_F_RXFULL 3
`define SFRI_F_RXHALF 4
`define SFRI_F_TXHALF 5
`define SFRI_F_WRITE_COLLISION_FLAG   7
`define SFRI_E_GATE   0
`define SFRI_E_RXDMA  6
`define SFRI_E_TXDMA  7
`define SFRI_IDE_WMASK_FIFO 8'hff
`define SFRI_IDE_WMASK_BUF  8'hc5

// ==========================================================
// Reset values and divider limit
`define SFRI_RST_CTRL 16'h0000
`define SFRI_RST_IDE  8'h00
`define SFRI_DIV_MAX  4'ha

`endif

// ==== sfri_pkg.sv ====
// Types shared by the serial port pair
`default_nettype none
package sfri_pkg;
  // ==========================================================
  // Shift engine states
  typedef enum logic [1:0] {
    SFRI_IDLE = 2'b01,
    SFRI_RUN  = 2'b10
  } sfri_state_e;
  typedef logic [15:0] sfri_word_t;
endpackage
`default_nettype wire

// ==== sfri_top.sv ====
// Serial port pair: FIFO port, single buffer port and register decode
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "sfri_consts.svh"

module sfri_port import sfri_pkg::*; #(
  parameter bit HAS_FIFO = 1'b1,
  parameter int DEPTH    = 4,
  parameter int NGRP     = 3
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            resetn,
  // Register access
  input  wire logic            sel,
  input  wire logic [4:0]      addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  input  wire logic            dma_access,
  output logic      [31:0]     rdata,
  // Link pins, one slot per pin group
  input  wire logic [NGRP-1:0] sck_i,
  output logic      [NGRP-1:0] sck_o,
  output logic      [NGRP-1:0] sck_oe,
  input  wire logic [NGRP-1:0] mo_i,
  output logic      [NGRP-1:0] mo_o,
  output logic      [NGRP-1:0] mo_oe,
  input  wire logic [NGRP-1:0] mi_i,
  output logic      [NGRP-1:0] mi_o,
  output logic      [NGRP-1:0] mi_oe,
  // Requests
  output logic                 irq,
  output logic                 dma_tx_req,
  output logic                 dma_rx_req
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ==========================================================
  // Decode
  wire wr_ctrl  = sel & wr & (addr == `SFRI_OFS_CTRL);
  wire wr_flags = sel & wr & (addr == `SFRI_OFS_FLAGS);
  wire wr_data  = sel & wr & (addr == `SFRI_OFS_DATA);
  wire wr_ide   = sel & wr & (addr == `SFRI_OFS_IDE);
  wire rd_data  = sel & rd & (addr == `SFRI_OFS_DATA);
  wire [7:0] ide_wmask = HAS_FIFO ? `SFRI_IDE_WMASK_FIFO : `SFRI_IDE_WMASK_BUF;

  logic [15:0] ctrl_ff;
  logic [7:0]  ide_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= `SFRI_RST_CTRL;
      ide_ff  <= `SFRI_RST_IDE;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wdata[15:0] & `SFRI_CTRL_WMASK; // [RULE25]
      end
      if (wr_ide) begin
        ide_ff <= wdata[7:0] & ide_wmask; // [RULE21] [RULE25]
      end
    end
  end

  wire       role_select        = ctrl_ff[`SFRI_C_ROLE];
  wire       word_width_sel     = ctrl_ff[`SFRI_C_WIDTH];
  wire       bit_order_sel      = ctrl_ff[`SFRI_C_ORDER];
  wire       capture_edge_sel   = ctrl_ff[`SFRI_C_CAPT];
  wire       clock_idle_level   = ctrl_ff[`SFRI_C_IDLE];
  wire       port_enable        = ctrl_ff[`SFRI_C_EN];
  wire [3:0] clock_divider_code = ctrl_ff[`SFRI_C_DIV];
  wire [1:0] pin_group_sel      = ctrl_ff[`SFRI_C_GRP];
  wire       cpu_irq_gate       = ide_ff[`SFRI_E_GATE];
  wire       tx_dma_request_en  = ide_ff[`SFRI_E_TXDMA];
  wire       rx_dma_request_en  = ide_ff[`SFRI_E_RXDMA];

  // ==========================================================
  // Pin synchronisers and group select
  logic [NGRP-1:0] sck_s1_ff, sck_s2_ff, mo_s1_ff, mo_s2_ff, mi_s1_ff, mi_s2_ff;
  logic            sck_prev_ff;
  logic [NGRP-1:0] grp_hot;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sck_s1_ff <= '0;
      sck_s2_ff <= '0;
      mo_s1_ff  <= '0;
      mo_s2_ff  <= '0;
      mi_s1_ff  <= '0;
      mi_s2_ff  <= '0;
    end else begin
      sck_s1_ff <= sck_i;
      sck_s2_ff <= sck_s1_ff;
      mo_s1_ff  <= mo_i;
      mo_s2_ff  <= mo_s1_ff;
      mi_s1_ff  <= mi_i;
      mi_s2_ff  <= mi_s1_ff;
    end
  end

  // Codes beyond the group count select no pins at all
  wire sck_sel  = |(sck_s2_ff & grp_hot); // [RULE22]
  wire mo_sel   = |(mo_s2_ff & grp_hot);
  wire mi_sel   = |(mi_s2_ff & grp_hot);
  wire sck_edge = sck_sel ^ sck_prev_ff;
  wire din      = role_select ? mi_sel : mo_sel;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sck_prev_ff <= 1'b0;
    end else begin
      sck_prev_ff <= sck_sel;
    end
  end

  // ==========================================================
  // Transmit and receive FIFOs (depth one on the buffer port)
  sfri_word_t    tx_mem [DEPTH];
  sfri_word_t    rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
  logic [CW-1:0] tx_cnt_ff, rx_cnt_ff;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  wire        tx_full  = (tx_cnt_ff == CW'(DEPTH));
  wire        rx_full  = (rx_cnt_ff == CW'(DEPTH));
  wire        tx_avail = (tx_cnt_ff != '0);
  wire        rx_avail = (rx_cnt_ff != '0);
  logic       tx_pop, frame_end, frame_start;
  sfri_word_t rx_word;
  wire        tx_push = wr_data & ~tx_full; // [RULE15]
  wire        rx_push = frame_end & ~rx_full;
  wire        rx_pop  = rd_data & rx_avail; // [RULE15]
  wire [CW-1:0] nxt_tx_cnt = CW'(tx_cnt_ff + CW'(tx_push) - CW'(tx_pop));
  wire [CW-1:0] nxt_rx_cnt = CW'(rx_cnt_ff + CW'(rx_push) - CW'(rx_pop));

  always_ff @(posedge mclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_ff] <= wdata[15:0];
    end
    if (rx_push) begin
      rx_mem[rx_wp_ff] <= rx_word;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_wp_ff  <= '0;
      tx_rp_ff  <= '0;
      rx_wp_ff  <= '0;
      rx_rp_ff  <= '0;
      tx_cnt_ff <= '0;
      rx_cnt_ff <= '0;
    end else begin
      tx_wp_ff  <= tx_push ? ptr_inc(tx_wp_ff) : tx_wp_ff;
      tx_rp_ff  <= tx_pop  ? ptr_inc(tx_rp_ff) : tx_rp_ff;
      rx_wp_ff  <= rx_push ? ptr_inc(rx_wp_ff) : rx_wp_ff;
      rx_rp_ff  <= rx_pop  ? ptr_inc(rx_rp_ff) : rx_rp_ff;
      tx_cnt_ff <= nxt_tx_cnt;
      rx_cnt_ff <= nxt_rx_cnt;
    end
  end

  // ==========================================================
  // Clock divider, enable pulse per serial clock edge
  sfri_state_e state_ff;
  logic [9:0]  div_cnt_ff;
  wire  [3:0]  code_c = (clock_divider_code > `SFRI_DIV_MAX) ? `SFRI_DIV_MAX
                                                              : clock_divider_code;
  // Half period in mclk cycles; codes 0 and 1 both reach the one-cycle floor
  wire  [9:0]  half_w = (code_c == 4'h0) ? 10'h001
                                         : 10'(10'h001 << (code_c - 4'h1)); // [RULE4]
  wire         m_run  = port_enable & role_select & (state_ff == SFRI_RUN);
  wire         tick   = m_run & (div_cnt_ff == 10'(half_w - 10'h001)); // [RULE4]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_ff <= 10'h000;
    end else begin
      div_cnt_ff <= (!m_run || tick) ? 10'h000 : 10'(div_cnt_ff + 10'h001);
    end
  end

  // ==========================================================
  // Shift engine
  sfri_word_t tx_sh_ff, rx_sh_ff, nxt_rx_sh;
  logic [4:0] edge_idx_ff;
  logic       loaded_ff, tgl_ff;

  assign tx_pop      = port_enable & (state_ff == SFRI_IDLE) & ~loaded_ff & tx_avail;
  wire   s_start     = port_enable & ~role_select & (state_ff == SFRI_IDLE) & sck_edge;
  wire   m_start     = port_enable & role_select & (state_ff == SFRI_IDLE) & loaded_ff;
  assign frame_start = s_start | m_start;
  // Slave: the edge that wakes the engine is already the first edge of the frame
  wire   edge_ev  = (state_ff == SFRI_RUN) ? (role_select ? tick : sck_edge) : s_start;
  wire   capture  = (edge_idx_ff[0] == capture_edge_sel); // [RULE7]
  wire   last_idx = (edge_idx_ff == (word_width_sel ? 5'h1f : 5'h0f)); // [RULE2]
  assign frame_end = edge_ev & last_idx;

  always_comb begin
    nxt_rx_sh = rx_sh_ff;
    if (edge_ev && capture) begin
      nxt_rx_sh = bit_order_sel ? {din, rx_sh_ff[15:1]} : {rx_sh_ff[14:0], din}; // [RULE1]
    end
  end
  // LSB-first bits enter at the top, so an 8-bit word sits in the upper byte
  assign rx_word = word_width_sel ? nxt_rx_sh
                 : (bit_order_sel ? {8'h00, nxt_rx_sh[15:8]} : {8'h00, nxt_rx_sh[7:0]});
  wire out_bit = bit_order_sel ? tx_sh_ff[0]
               : (word_width_sel ? tx_sh_ff[15] : tx_sh_ff[7]); // [RULE1] [RULE2]
  wire sck_level = clock_idle_level ^ tgl_ff; // [RULE6]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff    <= SFRI_IDLE;
      tx_sh_ff    <= 16'h0000;
      rx_sh_ff    <= 16'h0000;
      edge_idx_ff <= 5'h00;
      loaded_ff   <= 1'b0;
      tgl_ff      <= 1'b0;
    end else if (!port_enable) begin
      state_ff    <= SFRI_IDLE; // [RULE5]
      tx_sh_ff    <= 16'h0000;
      edge_idx_ff <= 5'h00;
      loaded_ff   <= 1'b0;
      tgl_ff      <= 1'b0;
    end else begin
      rx_sh_ff <= nxt_rx_sh;
      if (tx_pop) begin
        tx_sh_ff  <= tx_mem[tx_rp_ff];
        loaded_ff <= 1'b1;
      end
      if (m_start) begin
        state_ff <= SFRI_RUN; // [RULE3]
      end
      if (edge_ev) begin
        tgl_ff      <= role_select & ~tgl_ff;
        edge_idx_ff <= 5'(edge_idx_ff + 5'h01);
        state_ff    <= SFRI_RUN;
        if (!capture && edge_idx_ff != 5'h00) begin
          tx_sh_ff <= bit_order_sel ? {1'b0, tx_sh_ff[15:1]} : {tx_sh_ff[14:0], 1'b0};
        end
        // A slave with nothing queued shifts out zeros next frame
        if (last_idx) begin
          state_ff    <= SFRI_IDLE;
          edge_idx_ff <= 5'h00;
          tgl_ff      <= 1'b0;
          tx_sh_ff    <= 16'h0000;
          loaded_ff   <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Pin drive per group
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    assign grp_hot[g] = (pin_group_sel == 2'(g)); // [RULE22]
    assign sck_o[g]   = sck_level;
    assign sck_oe[g]  = grp_hot[g] & port_enable & role_select; // [RULE3]
    assign mo_o[g]    = out_bit;
    assign mo_oe[g]   = grp_hot[g] & port_enable & role_select;
    assign mi_o[g]    = out_bit;
    assign mi_oe[g]   = grp_hot[g] & port_enable & ~role_select;
  end

  // ==========================================================
  // Flags; a hardware set wins over a same-cycle clear
  logic write_collision_flag_ff, txe_ff, rxne_ff, done_ff;
  wire  w1c_write_collision_flag = wr_flags & wdata[`SFRI_F_WRITE_COLLISION_FLAG];
  wire  tx_empty_ev = tx_avail & (nxt_tx_cnt == '0);
  // A write that finds no room is refused, and counts as a collision too
  wire  nxt_write_collision_flag = (wr_data & ((state_ff == SFRI_RUN) | tx_full))
                 | (write_collision_flag_ff & ~w1c_write_collision_flag); // [RULE8] [RULE24]
  wire  nxt_txe  = tx_empty_ev
                 | (txe_ff & ~(wr_flags & wdata[`SFRI_F_TXE]) & ~(wr_data & dma_access)); // [RULE12]
  wire  nxt_rxne = HAS_FIFO & (rx_avail | (rxne_ff & ~(wr_flags & wdata[`SFRI_F_RXNE]))); // [RULE13]
  wire  nxt_done = frame_end
                 | (done_ff & ~frame_start & ~(wr_flags & wdata[`SFRI_F_DONE])); // [RULE14]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      write_collision_flag_ff <= 1'b0;
      txe_ff  <= 1'b0;
      rxne_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      write_collision_flag_ff <= nxt_write_collision_flag;
      txe_ff  <= nxt_txe;
      rxne_ff <= nxt_rxne;
      done_ff <= nxt_done;
    end
  end

  wire write_collision_flag = write_collision_flag_ff;
  wire tx_empty_flag        = txe_ff;
  wire rx_not_empty_flag    = rxne_ff;
  wire transfer_done_flag   = done_ff;
  wire tx_below_half_flag   = HAS_FIFO & (tx_cnt_ff < CW'(DEPTH / 2)); // [RULE9]
  wire rx_above_half_flag   = HAS_FIFO & (rx_cnt_ff > CW'(DEPTH / 2)); // [RULE10]
  wire rx_full_flag         = HAS_FIFO & rx_full; // [RULE11]
  wire [7:0] flag_vec = {write_collision_flag, 1'b0, tx_below_half_flag, rx_above_half_flag,
                         rx_full_flag, tx_empty_flag, rx_not_empty_flag,
                         transfer_done_flag}; // [RULE21]

  // ==========================================================
  // Interrupt and DMA requests
  wire [4:0] sub_irq = flag_vec[5:1] & ide_ff[5:1]; // [RULE19]
  assign irq        = cpu_irq_gate & ((|sub_irq) | (~HAS_FIFO & transfer_done_flag)); // [RULE20]
  assign dma_tx_req = tx_dma_request_en & tx_empty_flag; // [RULE17]
  assign dma_rx_req = rx_dma_request_en
                    & (HAS_FIFO ? rx_not_empty_flag : transfer_done_flag); // [RULE18] [RULE23]

  // ==========================================================
  // Read data, one cycle after the strobe
  logic [31:0] rdata_ff;
  wire  [31:0] rd_mux = (addr == `SFRI_OFS_CTRL)  ? {16'h0000, ctrl_ff}
                      : (addr == `SFRI_OFS_FLAGS) ? {24'h000000, flag_vec}
                      : (addr == `SFRI_OFS_DATA)  ? {16'h0000, rx_avail ? rx_mem[rx_rp_ff] : 16'h0000}
                      : (addr == `SFRI_OFS_IDE)   ? {24'h000000, ide_ff}
                      : 32'h0000_0000;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= (sel & rd) ? rd_mux : 32'h0000_0000;
    end
  end
  assign rdata = rdata_ff;

  // ==========================================================
  // Checks
  logic [10:0] gap_ff;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gap_ff <= 11'h000;
    end else begin
      gap_ff <= (!m_run || tick) ? 11'h000 : 11'(gap_ff + 11'h001);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  div_gap_a: assert property (tick |-> gap_ff == 11'(half_w - 10'h001)) // [RULE4]
    else $error("divider edge spacing wrong");
  frame_len_a: assert property (frame_end |-> edge_idx_ff == (word_width_sel ? 5'h1f : 5'h0f)) // [RULE2]
    else $error("frame edge count wrong");
  port_off_a: assert property (!port_enable |-> !(|{sck_oe, mo_oe, mi_oe}) // [RULE5]
                               ##1 state_ff == SFRI_IDLE)
    else $error("disabled port still active");
  idle_clock_a: assert property (role_select && state_ff == SFRI_IDLE |-> sck_o[0] == clock_idle_level) // [RULE6]
    else $error("serial clock not at idle level");
  write_collision_flag_set_a: assert property (wr_data && state_ff == SFRI_RUN |=> write_collision_flag) // [RULE24]
    else $error("collision not flagged");
  write_collision_flag_hold_a: assert property (write_collision_flag && !w1c_write_collision_flag |=> write_collision_flag) // [RULE8]
    else $error("collision flag dropped");
  done_busy_a: assert property (state_ff == SFRI_RUN |-> !transfer_done_flag) // [RULE14]
    else $error("done flag set while busy");
  done_set_a: assert property (frame_end |=> transfer_done_flag [*1] ##1 1'b1) // [RULE14]
    else $error("done flag not set after frame");
  rx_full_a: assert property ($rose(rx_full_flag) |-> $past(rx_push)) // [RULE11]
    else $error("receive full without a push");
  irq_gate_a: assert property (!cpu_irq_gate |-> !irq) // [RULE20]
    else $error("interrupt raised while gated");
  tx_dma_a: assert property ($rose(tx_empty_flag) && tx_dma_request_en |-> dma_tx_req) // [RULE17]
    else $error("transmit DMA request missing");
endmodule

module sfri_top import sfri_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        dma_access,
  output logic      [31:0] rdata,
  // FIFO port pins, three groups
  input  wire logic [2:0]  fa_sck_i,
  output logic      [2:0]  fa_sck_o,
  output logic      [2:0]  fa_sck_oe,
  input  wire logic [2:0]  fa_mo_i,
  output logic      [2:0]  fa_mo_o,
  output logic      [2:0]  fa_mo_oe,
  input  wire logic [2:0]  fa_mi_i,
  output logic      [2:0]  fa_mi_o,
  output logic      [2:0]  fa_mi_oe,
  // Buffer port pins, two groups
  input  wire logic [1:0]  fb_sck_i,
  output logic      [1:0]  fb_sck_o,
  output logic      [1:0]  fb_sck_oe,
  input  wire logic [1:0]  fb_mo_i,
  output logic      [1:0]  fb_mo_o,
  output logic      [1:0]  fb_mo_oe,
  input  wire logic [1:0]  fb_mi_i,
  output logic      [1:0]  fb_mi_o,
  output logic      [1:0]  fb_mi_oe,
  // Requests
  output logic             fa_irq,
  output logic             fa_dma_tx_req,
  output logic             fa_dma_rx_req,
  output logic             fb_irq,
  output logic             fb_dma_tx_req,
  output logic             fb_dma_rx_req
);
  logic [31:0] rdata_a, rdata_b;
  wire         in_map = (addr[7:6] == 2'h0);
  wire         sel_a  = in_map & ~addr[`SFRI_PORT_SEL_BIT];
  wire         sel_b  = in_map & addr[`SFRI_PORT_SEL_BIT];

  sfri_port #(.HAS_FIFO(1'b1), .DEPTH(FIFO_DEPTH), .NGRP(3)) u_fifo_port (
    .mclk(mclk), .resetn(resetn), .sel(sel_a), .addr(addr[4:0]), .wdata(wdata),
    .wr(wr), .rd(rd), .dma_access(dma_access), .rdata(rdata_a),
    .sck_i(fa_sck_i), .sck_o(fa_sck_o), .sck_oe(fa_sck_oe),
    .mo_i(fa_mo_i), .mo_o(fa_mo_o), .mo_oe(fa_mo_oe),
    .mi_i(fa_mi_i), .mi_o(fa_mi_o), .mi_oe(fa_mi_oe),
    .irq(fa_irq), .dma_tx_req(fa_dma_tx_req), .dma_rx_req(fa_dma_rx_req)
  );

  sfri_port #(.HAS_FIFO(1'b0), .DEPTH(1), .NGRP(2)) u_buf_port (
    .mclk(mclk), .resetn(resetn), .sel(sel_b), .addr(addr[4:0]), .wdata(wdata),
    .wr(wr), .rd(rd), .dma_access(dma_access), .rdata(rdata_b),
    .sck_i(fb_sck_i), .sck_o(fb_sck_o), .sck_oe(fb_sck_oe),
    .mo_i(fb_mo_i), .mo_o(fb_mo_o), .mo_oe(fb_mo_oe),
    .mi_i(fb_mi_i), .mi_o(fb_mi_o), .mi_oe(fb_mi_oe),
    .irq(fb_irq), .dma_tx_req(fb_dma_tx_req), .dma_rx_req(fb_dma_rx_req)
  );

  // Unselected ports return zero, so an OR is the read mux
  assign rdata = rdata_a | rdata_b;
endmodule
`default_nettype wire

// ==== sfri_slave_model.sv ====
// External serial slave model for the FIFO port link
`timescale 1ns/100ps
`default_nettype none
module sfri_slave_model #(
  parameter logic [7:0] REPLY = 8'h35
) (
  // Link
  input  wire logic       sck,
  input  wire logic       mo,
  output logic            mi,
  // Bench side
  output logic      [7:0] got
);
  logic [7:0] rx_sh = 8'h00;
  logic [7:0] tx_sh = REPLY;
  int         cnt   = 0;
  // ==========================================================
  // Idle low, capture on first edge: sample on rise, launch on fall
  always @(posedge sck) begin
    rx_sh = {rx_sh[6:0], mo};
    cnt   = cnt + 1;
  end
  // Next reply is loaded at frame end so it is ready before the first edge
  always @(negedge sck) begin
    if (cnt == 8) begin
      got   = rx_sh;
      cnt   = 0;
      tx_sh = REPLY;
    end else begin
      tx_sh = {tx_sh[6:0], 1'b0};
    end
  end
  assign mi = tx_sh[7];
endmodule
`default_nettype wire

// ==== tb_spi_fifo_register_interface.sv ====
// Self-checking bench of the serial port pair
`timescale 1ns/100ps
`default_nettype none
module tb_spi_fifo_register_interface import sfri_pkg::*;;
  logic        mclk, resetn, wr, rd, dma_access, fb_sck, fb_mo;
  logic [7:0]  addr, sl_got;
  logic [31:0] wdata, rdata, d;
  logic [2:0]  fa_sck_o, fa_sck_oe, fa_mo_o, fa_mo_oe, fa_mi_o, fa_mi_oe;
  logic [1:0]  fb_sck_o, fb_sck_oe, fb_mo_o, fb_mo_oe, fb_mi_o, fb_mi_oe;
  logic        fa_irq, fa_txq, fa_rxq, fb_irq, fb_txq, fb_rxq, sl_mi;
  int          failures, tests_run;
  // Released link lines are pulled low
  wire logic   sl_sck = fa_sck_oe[0] ? fa_sck_o[0] : 1'b0;
  wire logic   sl_mo  = fa_mo_oe[0] ? fa_mo_o[0] : 1'b0;

  sfri_top #(.FIFO_DEPTH(4)) uut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .dma_access(dma_access), .rdata(rdata), .fa_sck_i(3'h0),
    .fa_sck_o(fa_sck_o), .fa_sck_oe(fa_sck_oe), .fa_mo_i(3'h0), .fa_mo_o(fa_mo_o),
    .fa_mo_oe(fa_mo_oe), .fa_mi_i({2'h0, sl_mi}), .fa_mi_o(fa_mi_o), .fa_mi_oe(fa_mi_oe),
    .fb_sck_i({1'b0, fb_sck}), .fb_sck_o(fb_sck_o), .fb_sck_oe(fb_sck_oe),
    .fb_mo_i({1'b0, fb_mo}), .fb_mo_o(fb_mo_o), .fb_mo_oe(fb_mo_oe), .fb_mi_i(2'h0),
    .fb_mi_o(fb_mi_o), .fb_mi_oe(fb_mi_oe), .fa_irq(fa_irq), .fa_dma_tx_req(fa_txq),
    .fa_dma_rx_req(fa_rxq), .fb_irq(fb_irq), .fb_dma_tx_req(fb_txq), .fb_dma_rx_req(fb_rxq));
  sfri_slave_model #(.REPLY(8'h35)) partner (.sck(sl_sck), .mo(sl_mo), .mi(sl_mi), .got(sl_got));

  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v, input logic dm = 1'b0);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    dma_access <= dm;
    @(posedge mclk);
    wr <= 1'b0;
    dma_access <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  // Polls the done flag, bounded so a dead link cannot hang the run
  task automatic wait_done(input logic [7:0] a);
    int n;
    n = 0;
    rreg(a);
    while (d[0] !== 1'b1 && n < 200) begin
      rreg(a);
      n++;
    end
    chk({31'h0, d[0]}, 32'h1);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [7:0] ad [7] = '{8'h00, 8'h0c, 8'h10, 8'h20, 8'h2c, 8'h30, 8'h40};
    foreach (ad[i]) begin
      rreg(ad[i]);
      chk(d, 32'h0);
    end
    wreg(8'h00, 32'hffffffff);
    rreg(8'h00);
    chk(d, 32'h0000cf9f);
    wreg(8'h30, 32'hffffffff);
    rreg(8'h30);
    chk(d, 32'h000000c5);
    wreg(8'h00, 32'h0);
    wreg(8'h30, 32'h0);
    wreg(8'h40, 32'hffffffff);
    rreg(8'h40);
    chk(d, 32'h0);
  endtask
  // Divider code 3 gives the 320 ns link clock the partner needs after the pin synchronisers
  task automatic t_master;
    wreg(8'h10, 32'hc0);
    wreg(8'h00, 32'h381);
    wreg(8'h0c, 32'ha5);
    wait_done(8'h04);
    chk({24'h0, sl_got}, 32'ha5);
    chk({26'h0, fa_mi_oe, fa_mo_oe}, 32'h1);
    rreg(8'h04);
    chk(d, 32'h27);
    chk({30'h0, fa_txq, fa_rxq}, 32'h3);
    rreg(8'h0c);
    chk(d, 32'h35);
    wreg(8'h04, 32'h07);
    rreg(8'h04);
    chk(d, 32'h20);
    wreg(8'h00, 32'h385);
    wreg(8'h0c, 32'h01, 1'b1);
    wait_done(8'h04);
    chk({24'h0, sl_got}, 32'h80);
    rreg(8'h0c);
    chk(d, 32'hac);
    wreg(8'h04, 32'h01);
    wreg(8'h00, 32'h383);
    wreg(8'h0c, 32'h1234);
    wait_done(8'h04);
    chk({24'h0, sl_got}, 32'h34);
    rreg(8'h0c);
    chk(d, 32'h3535);
  endtask
  task automatic t_irq;
    wreg(8'h10, 32'h04);
    @(negedge mclk);
    chk({31'h0, fa_irq}, 32'h0);
    wreg(8'h10, 32'h05);
    @(negedge mclk);
    chk({31'h0, fa_irq}, 32'h1);
    wreg(8'h10, 32'h20);
    @(negedge mclk);
    chk({31'h0, fa_irq}, 32'h0);
  endtask
  task automatic t_fill;
    wreg(8'h00, 32'h0);
    wreg(8'h10, 32'h0);
    wreg(8'h0c, 32'h11);
    rreg(8'h04);
    chk(d & 32'ha0, 32'h20);
    repeat (4) wreg(8'h0c, 32'h22);
    rreg(8'h04);
    chk(d & 32'ha0, 32'h80);
    chk({29'h0, fa_sck_oe}, 32'h0);
    wreg(8'h04, 32'h80);
    rreg(8'h04);
    chk(d & 32'h80, 32'h0);
  endtask
  task automatic t_bslave;
    logic [7:0] v = 8'h96;
    wreg(8'h20, 32'h91);
    @(negedge mclk);
    chk({30'h0, fb_sck_oe[0], fb_sck_o[0]}, 32'h3);
    wreg(8'h20, 32'h80);
    wreg(8'h30, 32'h40);
    @(negedge mclk);
    chk({31'h0, fb_sck_oe[0]}, 32'h0);
    for (int i = 7; i >= 0; i--) begin
      fb_mo <= v[i];
      repeat (4) @(posedge mclk);
      fb_sck <= 1'b1;
      if (i == 4) begin
        wreg(8'h2c, 32'ha5);
      end
      repeat (4) @(posedge mclk);
      fb_sck <= 1'b0;
    end
    fb_mo <= ~v[0];
    repeat (20) @(posedge mclk);
    rreg(8'h24);
    chk(d, 32'h85);
    chk({31'h0, fb_rxq}, 32'h1);
    chk({28'h0, fb_mi_oe, fb_mo_oe}, 32'h4);
    chk({30'h0, fb_mi_o}, 32'h3);
    chk({30'h0, fb_irq, fb_txq}, 32'h0);
    rreg(8'h2c);
    chk(d, 32'h96);
  endtask

  task automatic complete_run;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #400000;
    failures++;
    complete_run();
  end
  initial begin
    {resetn, wr, rd, dma_access, fb_sck, fb_mo, addr, wdata} = '0;
    failures = 0;
    tests_run = 0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_master();
    t_irq();
    t_fill();
    t_bslave();
    complete_run();
  end
endmodule
`default_nettype wire
